// ---- hdl/hg_guard.sv ----
// Password-guarded hangup guard, top level
`timescale 1ns/1ps
module hg_guard #(
  parameter int COUNT_W = 16,
  parameter int PULSE_W = 2
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic soft_reset_out,
  output logic guard_irq_out,
  output logic nmi_sel_out,
  output logic nmi_edge_out
);
  hg_tick_if tick ();
  hg_pkg::hg_state_t state_r, state_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [hg_pkg::ST_W-1:0] st_r, st_nxt;
  logic [hg_pkg::ST_W-1:0] st_set, st_clr;
  logic [hg_pkg::ST_W-1:0] mask_r, mask_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [PULSE_W-1:0] pulse_r, pulse_nxt;
  logic soft_r, soft_nxt;
  logic irq_r, irq_nxt;
  logic nmi_sel_nxt, nmi_edge_nxt;
  logic ctl_wr, st_wr, mask_wr;
  logic key_ok, key_bad, dog_fire, in_reset;

  // ==========================================
  // Parameter checks
  initial begin
    if (COUNT_W != 16) $error("Guard counter width must be 16");
    if (hg_pkg::RESET_PULSE < 1 || hg_pkg::RESET_PULSE > 2 ** PULSE_W) $error("Soft reset pulse does not fit");
  end

  // ==========================================
  // Guard counter
  hg_counter #(.WIDTH(COUNT_W)) u_counter (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .tick(tick)
  );

  // ==========================================
  // Bus decode and counter steering
  assign in_reset = state_r == hg_pkg::HG_RESET;
  assign ctl_wr = wr_in && addr_in == hg_pkg::ADDR_CONTROL;
  assign st_wr = wr_in && addr_in == hg_pkg::ADDR_STATUS;
  assign mask_wr = wr_in && addr_in == hg_pkg::ADDR_MASK;
  assign key_ok = ctl_wr && wdata_in[15:8] == hg_pkg::PASSWORD;
  assign key_bad = ctl_wr && wdata_in[15:8] != hg_pkg::PASSWORD;
  assign dog_fire = tick.expire && !ctl_r[hg_pkg::CTL_TIMER_MODE];
  // Writes during the soft reset must not disturb the restart
  assign tick.clear = key_ok && !in_reset && wdata_in[hg_pkg::CTL_CLEAR];
  assign tick.run = !ctl_r[hg_pkg::CTL_HOLD] && !in_reset;
  assign tick.sel = ctl_r[hg_pkg::CTL_SEL_LSB +: hg_pkg::CTL_SEL_W];

  // ==========================================
  // Control register
  always_comb begin
    ctl_nxt = ctl_r;
    if (in_reset) begin
      ctl_nxt = hg_pkg::CTL_RESET; // Soft reset returns control to default
    end else if (key_ok) begin
      ctl_nxt = wdata_in[7:0];
      ctl_nxt[hg_pkg::CTL_CLEAR] = 1'b0; // Clear is a self-resetting action
    end
    nmi_sel_nxt = ctl_nxt[hg_pkg::CTL_NMI_SEL];
    nmi_edge_nxt = ctl_nxt[hg_pkg::CTL_NMI_EDGE];
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_r <= hg_pkg::CTL_RESET;
      nmi_sel_out <= 1'b0;
      nmi_edge_out <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      nmi_sel_out <= nmi_sel_nxt;
      nmi_edge_out <= nmi_edge_nxt;
    end
  end

  // ==========================================
  // Soft reset sequencer
  always_comb begin
    state_nxt = state_r;
    pulse_nxt = pulse_r;
    unique case (state_r)
      hg_pkg::HG_RUN: begin
        if (key_bad || dog_fire) begin
          state_nxt = hg_pkg::HG_RESET;
          pulse_nxt = PULSE_W'(hg_pkg::RESET_PULSE - 1);
        end
      end
      hg_pkg::HG_RESET: begin
        if (pulse_r == '0) begin
          state_nxt = hg_pkg::HG_RUN;
        end else begin
          pulse_nxt = pulse_r - 1'b1;
        end
      end
      default: state_nxt = hg_pkg::HG_RUN;
    endcase
    soft_nxt = state_nxt == hg_pkg::HG_RESET;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= hg_pkg::HG_RUN;
      pulse_r <= '0;
      soft_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pulse_r <= pulse_nxt;
      soft_r <= soft_nxt;
    end
  end

  // ==========================================
  // Sticky flags, one slice per status bit
  assign st_set[hg_pkg::ST_EXPIRE] = tick.expire;
  assign st_set[hg_pkg::ST_KEY_FAULT] = key_bad;
  assign st_clr = st_wr ? wdata_in[hg_pkg::ST_W-1:0] : '0;
  for (genvar i = 0; i < hg_pkg::ST_W; i++) begin : g_flag
    // Set wins over a clear in the same cycle
    assign st_nxt[i] = st_set[i] || (st_r[i] && !st_clr[i]);
    a_flag_sticky: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (st_r[i] && !st_clr[i]) |=> st_r[i])
      else $error("Guard flag lost");
    a_flag_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (st_clr[i] && !st_set[i]) |=> !st_r[i])
      else $error("Guard flag not cleared");
  end

  // ==========================================
  // Interrupt enable mask and request
  // Flags survive the soft reset so software can see the cause; only rst_b_in or a status write clears them.
  always_comb begin
    mask_nxt = mask_r;
    if (mask_wr) begin
      mask_nxt = wdata_in[hg_pkg::ST_W-1:0];
    end
    irq_nxt = ctl_r[hg_pkg::CTL_TIMER_MODE] && |(st_nxt & mask_nxt);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================
  // Read port
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        hg_pkg::ADDR_CONTROL: rdata_nxt = {hg_pkg::PASSWORD, ctl_r};
        hg_pkg::ADDR_STATUS: rdata_nxt = {14'h0000, st_r};
        hg_pkg::ADDR_MASK: rdata_nxt = {14'h0000, mask_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign soft_reset_out = soft_r;
  assign guard_irq_out = irq_r;

  // ==========================================
  // Checks on the soft reset
  a_bad_key_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (key_bad && state_r == hg_pkg::HG_RUN) |=> soft_reset_out ##1 soft_reset_out)
    else $error("Bad key gave no soft reset");

  a_bad_key_keep: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (key_bad && state_r == hg_pkg::HG_RUN) |=> ctl_r == $past(ctl_r))
    else $error("Bad key changed control");

  a_dog_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (tick.expire && !ctl_r[hg_pkg::CTL_TIMER_MODE] && state_r == hg_pkg::HG_RUN) |=> soft_reset_out)
    else $error("Expiry gave no soft reset");

  a_timer_no_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (state_r == hg_pkg::HG_RUN && !key_bad && (!tick.expire || ctl_r[hg_pkg::CTL_TIMER_MODE]))
    |=> !soft_reset_out) else $error("Spurious soft reset");

  a_pulse_len: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $rose(soft_reset_out) |=> soft_reset_out ##1 !soft_reset_out)
    else $error("Soft reset pulse length wrong");

  a_ctl_default: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    soft_reset_out |=> ctl_r == hg_pkg::CTL_RESET)
    else $error("Control not defaulted by soft reset");

  a_reset_holds: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    soft_reset_out |=> !tick.expire)
    else $error("Counter ran during soft reset");

  a_reset_ignores: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (in_reset && key_ok) |=> ctl_r == hg_pkg::CTL_RESET)
    else $error("Control written during soft reset");

  // ==========================================
  // Checks on the control register
  a_good_key_load: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (key_ok && state_r == hg_pkg::HG_RUN) |=> ctl_r[7:4] == $past(wdata_in[7:4]))
    else $error("Control not loaded");

  a_ctl_keep: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (!key_ok && !in_reset) |=> ctl_r == $past(ctl_r))
    else $error("Control changed without a write");

  a_hold_stop: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ctl_r[hg_pkg::CTL_HOLD] |=> !tick.expire)
    else $error("Held counter expired");

  a_nmi_bits: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (key_ok && state_r == hg_pkg::HG_RUN) |=> nmi_sel_out == $past(wdata_in[hg_pkg::CTL_NMI_SEL])
    && nmi_edge_out == $past(wdata_in[hg_pkg::CTL_NMI_EDGE]))
    else $error("NMI pin bits not loaded");

  // ==========================================
  // Checks on flags and interrupt
  a_flag_set: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (tick.expire || key_bad) |=> st_r != 2'b00)
    else $error("Guard flag not set");

  a_mask_load: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    mask_wr |=> mask_r == $past(wdata_in[hg_pkg::ST_W-1:0]))
    else $error("Mask not loaded");

  a_mask_keep: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !mask_wr |=> mask_r == $past(mask_r))
    else $error("Mask changed without a write");

  a_irq_gate: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    guard_irq_out |-> $past(mask_nxt) != 2'b00 && $past(ctl_r[hg_pkg::CTL_TIMER_MODE]))
    else $error("Interrupt without enable");

  a_irq_raise: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (ctl_r[hg_pkg::CTL_TIMER_MODE] && tick.expire && mask_nxt[hg_pkg::ST_EXPIRE]) |=> guard_irq_out)
    else $error("Timer expiry gave no interrupt");

  a_no_irq_dog: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !ctl_r[hg_pkg::CTL_TIMER_MODE] |=> !guard_irq_out)
    else $error("Interrupt in watchdog mode");

  // ==========================================
  // Checks on the read port
  a_read_ctl: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (rd_in && addr_in == hg_pkg::ADDR_CONTROL) |=> rdata_out == {hg_pkg::PASSWORD, $past(ctl_r)})
    else $error("Control read wrong");

  a_read_status: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (rd_in && addr_in == hg_pkg::ADDR_STATUS) |=> rdata_out == {14'h0000, $past(st_r)})
    else $error("Status read wrong");

  a_read_unmapped: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (rd_in && addr_in != hg_pkg::ADDR_CONTROL && addr_in != hg_pkg::ADDR_STATUS
    && addr_in != hg_pkg::ADDR_MASK) |=> rdata_out == 16'h0000)
    else $error("Unmapped read not zero");

  a_read_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !rd_in |=> rdata_out == 16'h0000)
    else $error("Read data outside its cycle");
endmodule

// ---- hdl/hg_pkg.sv ----
// Package of constants for the hangup guard block
package hg_pkg;
  // ==========================================
  // Register map
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [7:0] PASSWORD = 8'h5a;
  // ==========================================
  // Control fields
  localparam int CTL_HOLD = 7;
  localparam int CTL_NMI_EDGE = 6;
  localparam int CTL_NMI_SEL = 5;
  localparam int CTL_TIMER_MODE = 4;
  localparam int CTL_CLEAR = 3;
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_SEL_W = 2;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // ==========================================
  // Status fields
  localparam int ST_EXPIRE = 0;
  localparam int ST_KEY_FAULT = 1;
  localparam int ST_W = 2;
  // ==========================================
  // Interval taps, pulse length and sequencer states
  localparam int TAP_0 = 15;
  localparam int TAP_1 = 13;
  localparam int TAP_2 = 9;
  localparam int TAP_3 = 6;
  localparam int RESET_PULSE = 2;
  typedef enum logic [1:0] {HG_RUN, HG_RESET} hg_state_t;
endpackage

// ---- hdl/hg_tick_if.sv ----
// Interface between the counter and the control logic
`timescale 1ns/1ps
interface hg_tick_if;
  logic clear;
  logic run;
  logic [1:0] sel;
  logic expire;
  modport ctl (output clear, output run, output sel, input expire);
  modport cnt (input clear, input run, input sel, output expire);
endinterface

// ---- hdl/hg_counter.sv ----
// Guard counter with selectable interval taps
`timescale 1ns/1ps
module hg_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  hg_tick_if.cnt tick
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic expire_r;
  logic expire_nxt;
  logic hit;

  initial begin
    if (WIDTH != 16) $error("Guard counter width must be 16");
  end

  // ==========================================
  // Next state
  always_comb begin
    unique case (tick.sel)
      2'd0: hit = &count_r[hg_pkg::TAP_0:0];
      2'd1: hit = &count_r[hg_pkg::TAP_1:0];
      2'd2: hit = &count_r[hg_pkg::TAP_2:0];
      2'd3: hit = &count_r[hg_pkg::TAP_3:0];
    endcase
    count_nxt = count_r;
    expire_nxt = 1'b0;
    if (tick.clear) begin
      count_nxt = '0;
    end else if (tick.run) begin
      if (hit) begin
        count_nxt = '0;
        expire_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_r <= '0;
      expire_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign tick.expire = expire_r;

  // ==========================================
  // Checks
  a_restart_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    expire_r |-> count_r == '0) else $error("Counter not restarted at expiry");
  a_count_step: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (tick.run && !tick.clear && !hit) |=> count_r == $past(count_r) + 1'b1)
    else $error("Counter did not step");
endmodule

// ---- bench/hg_guard_test.sv ----
// Self-checking testbench for the hangup guard block
`timescale 1ns/1ps
module hg_guard_test;
  logic clock_in;
  logic rst_b_in;
  logic [3:0] addr_in;
  logic [15:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [15:0] rdata_out;
  logic soft_reset_out;
  logic guard_irq_out;
  logic nmi_sel_out;
  logic nmi_edge_out;
  logic [15:0] v;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  int t0;

  hg_guard dut_u (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .soft_reset_out(soft_reset_out),
    .guard_irq_out(guard_irq_out),
    .nmi_sel_out(nmi_sel_out),
    .nmi_edge_out(nmi_edge_out)
  );

  // ==========================================
  // Clock and cycle count
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) cyc <= cyc + 1;

  // ==========================================
  // Bus tasks and checks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    v = rdata_out;
  endtask

  // Bounded wait; n is the number of cycles spent
  task automatic wait_lvl(input logic which, input logic lvl, input int lim);
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while ((which ? guard_irq_out : soft_reset_out) !== lvl && n < lim);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog against hangs of the bench itself
  initial begin
    #2_000_000;
    num_errors++;
    final_report;
  end

  // ==========================================
  // Test sequence
  initial begin
    rst_b_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    rd(hg_pkg::ADDR_CONTROL); check(v, 16'h5a00);
    @(negedge clock_in); check(rdata_out, 16'h0000);
    rd(hg_pkg::ADDR_STATUS); check(v, 16'h0000);
    rd(hg_pkg::ADDR_MASK); check(v, 16'h0000);
    rd(4'hc); check(v, 16'h0000);
    wr(hg_pkg::ADDR_CONTROL, 16'h5a63);
    rd(hg_pkg::ADDR_CONTROL); check(v, 16'h5a63);
    check({14'h0, nmi_edge_out, nmi_sel_out}, 16'h0003);
    // Hold must stop the count although the interval is short
    wr(hg_pkg::ADDR_CONTROL, 16'h5a8b);
    n = 0;
    repeat (300) begin
      @(negedge clock_in);
      if (soft_reset_out !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    rd(hg_pkg::ADDR_CONTROL); check(v, 16'h5a83);
    // Watchdog expiry
    wr(hg_pkg::ADDR_CONTROL, 16'h5a0b);
    wait_lvl(1'b0, 1'b1, 300);
    check({15'h0, n >= 126 && n <= 136}, 16'h0001);
    wait_lvl(1'b0, 1'b0, 10);
    check(16'(n), 16'(hg_pkg::RESET_PULSE));
    rd(hg_pkg::ADDR_CONTROL); check(v, 16'h5a00);
    rd(hg_pkg::ADDR_STATUS); check(v, 16'h0001);
    // Wrong key: discarded and soft reset
    wr(hg_pkg::ADDR_CONTROL, 16'h125b);
    wait_lvl(1'b0, 1'b1, 4);
    check({15'h0, n <= 2}, 16'h0001);
    wait_lvl(1'b0, 1'b0, 10);
    rd(hg_pkg::ADDR_STATUS); check(v, 16'h0003);
    rd(hg_pkg::ADDR_CONTROL); check(v, 16'h5a00);
    wr(hg_pkg::ADDR_STATUS, 16'h0003);
    rd(hg_pkg::ADDR_STATUS); check(v, 16'h0000);
    // Interval timer mode
    wr(hg_pkg::ADDR_MASK, 16'h0001);
    wr(hg_pkg::ADDR_CONTROL, 16'h5a1b);
    wait_lvl(1'b1, 1'b1, 300);
    check({15'h0, n >= 126 && n <= 136}, 16'h0001);
    check({15'h0, soft_reset_out}, 16'h0000);
    t0 = cyc;
    wr(hg_pkg::ADDR_STATUS, 16'h0001);
    wait_lvl(1'b1, 1'b0, 10);
    wait_lvl(1'b1, 1'b1, 300);
    check(16'(cyc - t0), 16'h0080);
    // Masked: flag still set, no request
    wr(hg_pkg::ADDR_MASK, 16'h0000);
    wr(hg_pkg::ADDR_STATUS, 16'h0001);
    n = 0;
    repeat (200) begin
      @(negedge clock_in);
      if (guard_irq_out !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
    rd(hg_pkg::ADDR_STATUS); check(v, 16'h0001);
    // Pin reset clears the flags that a soft reset keeps
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    rd(hg_pkg::ADDR_STATUS); check(v, 16'h0000);
    rd(hg_pkg::ADDR_MASK); check(v, 16'h0000);
    rd(hg_pkg::ADDR_CONTROL); check(v, 16'h5a00);
    final_report;
  end
endmodule
